// >>> lpg_consts.svh
// Purpose: Offsets, field positions, reset values and sizes of the PWM generator
// Assumes: Included by lpg_pkg.sv and lpg_top.sv
// Notes:   Definitions only
`ifndef LPG_CONSTS_SVH
`define LPG_CONSTS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define LPG_NUM_LED  24
`define LPG_NUM_AUX  5
`define LPG_NUM_CNT  3

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LPG_OFF_CTRL 12'h000
`define LPG_OFF_STAT 12'h004
`define LPG_OFF_MASK 12'h008
`define LPG_OFF_ASEL 12'h00C
`define LPG_OFF_CFG0 12'h010
`define LPG_OFF_CFG1 12'h014
`define LPG_OFF_CFG2 12'h018
`define LPG_OFF_CNT  12'h01C
`define LPG_LED_BASE 12'h100
`define LPG_AUX_BASE 12'h180
`define LPG_CH_MASK  12'hF80

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define LPG_DIV_LSB  16
`define LPG_FALL_LSB 16
`define LPG_PER_RST  16'hFFFF
`define LPG_DIV_RST  8'h00
`define LPG_CH_RST   32'h0000_0000

`endif

// >>> lpg_pkg.sv
// Purpose: Types shared by the PWM generator
// Assumes: lpg_consts.svh holds the numbers
// Notes:   Types only
`include "lpg_consts.svh"

package lpg_pkg;
  typedef logic [31:0] lpg_word_t;
  typedef logic [15:0] lpg_stamp_t;
  typedef logic [7:0]  lpg_div_t;
  typedef logic [11:0] lpg_addr_t;
endpackage : lpg_pkg

// >>> lpg_top.sv
// Purpose: 24-channel LED PWM plus 5-channel auxiliary PWM with APB registers
// Assumes: Single clock pclk; APB master keeps the protocol
// Notes:   Counter 0 drives LED channels, counters 1 and 2 serve the aux channels
`timescale 1ns/1ps
`default_nettype none
`include "lpg_consts.svh"

// How it works
// - 24 LED channels, shared period, own stamps
// - Full resolution only at maximum period
// - Period lasts one clock plus period times divider
// - Pulse lasts one clock plus difference times divider
// - Settings load together at boundary when pending
// - Interrupt when new settings become active
// - Rise zero, fall equals period: always on
// - Rise below fall: on at rise, off at fall
// - Both zero acts as fall one
// - Rise not below fall: always off
// - Two aux counters, any channel selects either
// - Five aux channels, same rules as LED
// - Aux waveforms drive GPIO outputs
module lpg_top (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire lpg_pkg::lpg_addr_t paddr,
  input  wire lpg_pkg::lpg_word_t pwdata,
  output var  lpg_pkg::lpg_word_t prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  output logic [23:0]            led_pwm,
  output logic [4:0]             aux_gpio
);
  import lpg_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Channel decode; priority order of the cases matters
  function automatic logic chan_on(input lpg_stamp_t cnt, input logic pre_zero,
                                   input lpg_stamp_t rise, input lpg_stamp_t fall,
                                   input lpg_stamp_t per);
    lpg_stamp_t f;
    // With a zero period and zero stamps the always-on case wins
    f = fall;
    if ((rise == 16'h0000) && (fall == per)) begin
      return 1'b1;
    end
    if ((rise == 16'h0000) && (fall == 16'h0000)) begin
      f = 16'h0001;
    end
    if (rise < f) begin
      // Extra single clock at the fall stamp gives the +1 clock width
      return (cnt >= rise) && ((cnt < f) || ((cnt == f) && pre_zero));
    end
    return 1'b0;
  endfunction : chan_on

  // Channel window decode of the address
  function automatic logic in_bank(input lpg_addr_t a, input lpg_addr_t base,
                                   input int n);
    return ((a & `LPG_CH_MASK) == base) && (int'(a[6:2]) < n);
  endfunction : in_bank

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0]  pend_r, pend_nxt;
  logic [2:0]  stat_r, stat_nxt;
  logic [2:0]  mask_r, mask_nxt;
  logic [4:0]  asel_r, asel_nxt;
  lpg_word_t   cfg_r  [`LPG_NUM_CNT];
  lpg_word_t   cfg_nxt[`LPG_NUM_CNT];
  lpg_word_t   led_sh_r  [`LPG_NUM_LED];
  lpg_word_t   led_sh_nxt[`LPG_NUM_LED];
  lpg_word_t   aux_sh_r  [`LPG_NUM_AUX];
  lpg_word_t   aux_sh_nxt[`LPG_NUM_AUX];
  lpg_word_t   prdata_nxt;
  lpg_word_t   prdata_r;
  logic        perr_r, perr_nxt;

  lpg_stamp_t  cnt_r  [`LPG_NUM_CNT];
  lpg_stamp_t  cnt_nxt[`LPG_NUM_CNT];
  lpg_div_t    pre_r  [`LPG_NUM_CNT];
  lpg_div_t    pre_nxt[`LPG_NUM_CNT];
  lpg_stamp_t  per_a_r  [`LPG_NUM_CNT];
  lpg_stamp_t  per_a_nxt[`LPG_NUM_CNT];
  lpg_div_t    div_a_r  [`LPG_NUM_CNT];
  lpg_div_t    div_a_nxt[`LPG_NUM_CNT];
  lpg_word_t   led_a_r  [`LPG_NUM_LED];
  lpg_word_t   led_a_nxt[`LPG_NUM_LED];
  lpg_word_t   aux_a_r  [`LPG_NUM_AUX];
  lpg_word_t   aux_a_nxt[`LPG_NUM_AUX];
  logic [23:0] led_r, led_nxt;
  logic [4:0]  aux_r, aux_nxt;

  logic [2:0]  bnd;
  logic [2:0]  load;
  logic        wr_acc;
  logic        setup;
  lpg_word_t   rd_val;
  logic        rd_ok;

  // ----------------------------------------------------------------
  // Boundary and load
  // ----------------------------------------------------------------
  // Boundary is the single clock where the counter sits on the period
  always_comb begin
    for (int k = 0; k < `LPG_NUM_CNT; k++) begin
      bnd[k]  = (cnt_r[k] == per_a_r[k]);
      load[k] = bnd[k] & pend_r[k];
    end
  end

  // Bus strobes; the slave answers every transfer without wait states
  assign setup   = psel & ~penable;
  assign wr_acc  = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = perr_r & psel & penable;
  // Level interrupt while any unmasked load flag stands
  assign irq     = |(stat_r & mask_r);
  assign led_pwm = led_r;
  assign aux_gpio = aux_r;

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  // Read mux; unmapped offsets read zero and flag an error
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (in_bank(paddr, `LPG_LED_BASE, `LPG_NUM_LED)) begin
      rd_val = led_sh_r[paddr[6:2]];
    end else if (in_bank(paddr, `LPG_AUX_BASE, `LPG_NUM_AUX)) begin
      rd_val = aux_sh_r[paddr[4:2]];
    end else begin
      case (paddr)
        `LPG_OFF_CTRL: rd_val = {29'd0, pend_r};
        `LPG_OFF_STAT: rd_val = {29'd0, stat_r};
        `LPG_OFF_MASK: rd_val = {29'd0, mask_r};
        `LPG_OFF_ASEL: rd_val = {27'd0, asel_r};
        `LPG_OFF_CFG0: rd_val = cfg_r[0];
        `LPG_OFF_CFG1: rd_val = cfg_r[1];
        `LPG_OFF_CFG2: rd_val = cfg_r[2];
        `LPG_OFF_CNT:  rd_val = {16'h0000, cnt_r[0]};
        default:       rd_ok  = 1'b0;
      endcase
    end
  end

  // Next register values; hardware set beats a software clear
  always_comb begin
    // Captured in setup, so the data already stand in the access phase
    prdata_nxt = setup ? rd_val : prdata_r;
    perr_nxt   = setup ? ~rd_ok : perr_r;
    mask_nxt   = mask_r;
    asel_nxt   = asel_r;
    cfg_nxt    = cfg_r;
    led_sh_nxt = led_sh_r;
    aux_sh_nxt = aux_sh_r;
    // A request written in the boundary clock waits for the next boundary
    pend_nxt   = pend_r & ~load;
    stat_nxt   = stat_r;
    if (wr_acc) begin
      if (in_bank(paddr, `LPG_LED_BASE, `LPG_NUM_LED)) begin
        led_sh_nxt[paddr[6:2]] = pwdata;
      end else if (in_bank(paddr, `LPG_AUX_BASE, `LPG_NUM_AUX)) begin
        aux_sh_nxt[paddr[4:2]] = pwdata;
      end else begin
        case (paddr)
          `LPG_OFF_CTRL: pend_nxt = pend_nxt | pwdata[2:0];
          `LPG_OFF_STAT: stat_nxt = stat_r & ~pwdata[2:0];
          `LPG_OFF_MASK: mask_nxt = pwdata[2:0];
          `LPG_OFF_ASEL: asel_nxt = pwdata[4:0];
          `LPG_OFF_CFG0: cfg_nxt[0] = pwdata;
          `LPG_OFF_CFG1: cfg_nxt[1] = pwdata;
          `LPG_OFF_CFG2: cfg_nxt[2] = pwdata;
          default: ;
        endcase
      end
    end
    stat_nxt = stat_nxt | load;
  end

  // Register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      perr_r   <= 1'b0;
      pend_r   <= 3'b000;
      stat_r   <= 3'b000;
      mask_r   <= 3'b000;
      asel_r   <= 5'b00000;
      for (int k = 0; k < `LPG_NUM_CNT; k++) begin
        cfg_r[k] <= {8'h00, `LPG_DIV_RST, `LPG_PER_RST};
      end
      for (int i = 0; i < `LPG_NUM_LED; i++) begin
        led_sh_r[i] <= `LPG_CH_RST;
      end
      for (int i = 0; i < `LPG_NUM_AUX; i++) begin
        aux_sh_r[i] <= `LPG_CH_RST;
      end
    end else begin
      prdata_r <= prdata_nxt;
      perr_r   <= perr_nxt;
      pend_r   <= pend_nxt;
      stat_r   <= stat_nxt;
      mask_r   <= mask_nxt;
      asel_r   <= asel_nxt;
      cfg_r    <= cfg_nxt;
      led_sh_r <= led_sh_nxt;
      aux_sh_r <= aux_sh_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Counters, active settings and outputs
  // ----------------------------------------------------------------
  // Boundary holds one clock only, so a period is 1 + period*divider clocks
  always_comb begin
    cnt_nxt   = cnt_r;
    pre_nxt   = pre_r;
    per_a_nxt = per_a_r;
    div_a_nxt = div_a_r;
    led_a_nxt = led_a_r;
    aux_a_nxt = aux_a_r;
    led_nxt   = led_r;
    aux_nxt   = aux_r;
    for (int k = 0; k < `LPG_NUM_CNT; k++) begin
      if (bnd[k]) begin
        cnt_nxt[k] = 16'h0000;
        pre_nxt[k] = 8'h00;
      end else if (pre_r[k] == div_a_r[k]) begin
        cnt_nxt[k] = cnt_r[k] + 16'h0001;
        pre_nxt[k] = 8'h00;
      end else begin
        pre_nxt[k] = pre_r[k] + 8'h01;
      end
      if (load[k]) begin
        per_a_nxt[k] = cfg_r[k][15:0];
        div_a_nxt[k] = cfg_r[k][`LPG_DIV_LSB +: 8];
      end
    end
    for (int i = 0; i < `LPG_NUM_LED; i++) begin
      if (load[0]) begin
        led_a_nxt[i] = led_sh_r[i];
      end
      // Resolution is 16-bit only when the period is all ones
      led_nxt[i] = chan_on(cnt_r[0], pre_r[0] == 8'h00, led_a_r[i][15:0],
                           led_a_r[i][`LPG_FALL_LSB +: 16], per_a_r[0]);
    end
    // Counter select acts at once; a switch mid-period may clip one pulse
    // Aux stamps follow whichever counter the channel selects at that boundary
    for (int i = 0; i < `LPG_NUM_AUX; i++) begin
      if (load[asel_r[i] ? 2 : 1]) begin
        aux_a_nxt[i] = aux_sh_r[i];
      end
      aux_nxt[i] = asel_r[i]
        ? chan_on(cnt_r[2], pre_r[2] == 8'h00, aux_a_r[i][15:0],
                  aux_a_r[i][`LPG_FALL_LSB +: 16], per_a_r[2])
        : chan_on(cnt_r[1], pre_r[1] == 8'h00, aux_a_r[i][15:0],
                  aux_a_r[i][`LPG_FALL_LSB +: 16], per_a_r[1]);
    end
  end

  // Engine flops; outputs are registered so the pins never glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < `LPG_NUM_CNT; k++) begin
        cnt_r[k]   <= 16'h0000;
        pre_r[k]   <= 8'h00;
        per_a_r[k] <= `LPG_PER_RST;
        div_a_r[k] <= `LPG_DIV_RST;
      end
      for (int i = 0; i < `LPG_NUM_LED; i++) begin
        led_a_r[i] <= `LPG_CH_RST;
      end
      for (int i = 0; i < `LPG_NUM_AUX; i++) begin
        aux_a_r[i] <= `LPG_CH_RST;
      end
      led_r <= 24'h00_0000;
      aux_r <= 5'b00000;
    end else begin
      cnt_r   <= cnt_nxt;
      pre_r   <= pre_nxt;
      per_a_r <= per_a_nxt;
      div_a_r <= div_a_nxt;
      led_a_r <= led_a_nxt;
      aux_a_r <= aux_a_nxt;
      led_r   <= led_nxt;
      aux_r   <= aux_nxt;
    end
  end

endmodule : lpg_top
`default_nettype wire

// >>> lpg_top_monitor.sv
// Purpose: Port checker for lpg_top
// Assumes: Register offsets from lpg_consts.svh, pready tied high
// Notes:   Bound into every lpg_top instance
`timescale 1ns/1ps
`default_nettype none
`include "lpg_consts.svh"
// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module lpg_top_monitor (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire lpg_pkg::lpg_addr_t paddr,
  input wire lpg_pkg::lpg_word_t pwdata,
  input wire lpg_pkg::lpg_word_t prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               irq,
  input wire logic [23:0]        led_pwm,
  input wire logic [4:0]         aux_gpio
);
  import lpg_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase, shared by the bus checks
  wire logic acc = psel && penable;
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc && paddr inside {[12'h020:12'h0FF]} |-> pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (acc && paddr <= `LPG_OFF_CNT |-> !pslverr)
    else $error("error on mapped access");
  a_err_gated: assert property (pslverr |-> acc) else $error("error outside access phase");
  // Read data must not drift between transfers
  a_prdata_hold: assert property (!psel |=> $stable(prdata)) else $error("prdata moved");
  a_irq_mask_off: assert property (acc && pwrite && paddr == `LPG_OFF_MASK &&
    pwdata[2:0] == 3'h0 |=> !irq) else $error("irq with all masked");
  a_out_idle_start: assert property ($rose(presetn) |-> led_pwm == 24'h00_0000 &&
    aux_gpio == 5'h00) else $error("outputs active after reset");
  a_irq_idle_start: assert property ($rose(presetn) |-> !irq) else $error("irq after reset");
  c_irq: cover property ($rose(irq));
  c_led: cover property ($rose(led_pwm[0]));
  c_err: cover property (pslverr);
endmodule : lpg_top_monitor

bind lpg_top lpg_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .led_pwm(led_pwm), .aux_gpio(aux_gpio));
`default_nettype wire

// >>> lpg_led_sink.sv
// Purpose: LED driver and GPIO pin model, counts lit clocks per channel
// Assumes: High on a channel means on
// Notes:   Counts only while meas is high, cleared otherwise
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Sink
// ------------------------------------------------------------
module lpg_led_sink (
  input  wire logic        pclk,
  input  wire logic        meas,
  input  wire logic [23:0] led_pwm,
  input  wire logic [4:0]  aux_gpio,
  output int               hi_cnt [29],
  output int               rise_cnt [29]
);
  logic [28:0] pins;
  logic [28:0] prev;
  assign pins = {aux_gpio, led_pwm};
  // A whole number of periods in the window makes the counts phase free
  always @(posedge pclk) begin
    for (int i = 0; i < 29; i++) begin
      hi_cnt[i] <= meas ? hi_cnt[i] + int'(pins[i]) : 0;
      rise_cnt[i] <= meas ? rise_cnt[i] + int'(pins[i] && !prev[i]) : 0;
    end
    prev <= pins;
  end
endmodule : lpg_led_sink
`default_nettype wire

// >>> tb.sv
// Purpose: Self-checking bench for lpg_top
// Assumes: Zero wait state APB slave, DIV is select plus one
// Notes:   Short periods keep the run brief
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module tb;
  import lpg_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, meas, pready, pslverr, irq, err_seen;
  lpg_addr_t   paddr;
  lpg_word_t   pwdata, prdata, q;
  logic [23:0] led_pwm;
  logic [4:0]  aux_gpio;
  int          hi_cnt [29], rise_cnt [29], hs [29], rs [29];
  int          bad_count, checked;
  lpg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .led_pwm(led_pwm), .aux_gpio(aux_gpio));
  lpg_led_sink u_sink (.pclk(pclk), .meas(meas), .led_pwm(led_pwm), .aux_gpio(aux_gpio),
    .hi_cnt(hi_cnt), .rise_cnt(rise_cnt));
  // 10 MHz clock
  always #50 pclk = ~pclk;
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input lpg_word_t exp, input lpg_word_t got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input lpg_addr_t a, input lpg_word_t d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      report_and_stop();
    end
    q = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next setup never re-raises psel in this time step
    @(posedge pclk);
  endtask : apb
  task automatic rd_chk(input string what, input lpg_addr_t a, input lpg_word_t exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, q);
  endtask : rd_chk
  // Waits for the given load flags, bounded
  task automatic wait_stat(input lpg_word_t want);
    q = ~want;
    for (int i = 0; i < 25000 && q !== want; i++) begin
      apb(1'b0, 12'h004, 32'h0000_0000);
    end
    chk("load flags", want, q);
    if (q !== want) begin
      report_and_stop();
    end
  endtask : wait_stat
  task automatic meas_win(input int n);
    meas <= 1'b1;
    repeat (n) @(posedge pclk);
    meas <= 1'b0;
    #1;
    hs = hi_cnt;
    rs = rise_cnt;
    @(posedge pclk);
  endtask : meas_win
  task automatic s_reset_values;
    rd_chk("cfg0 reset", 12'h010, 32'h0000_FFFF);
    chk("mapped no error", 1'b0, err_seen);
    rd_chk("led0 reset", 12'h100, 32'h0000_0000);
    apb(1'b1, 12'h040, 32'hFFFF_FFFF);
    chk("unmapped error", 1'b1, err_seen);
    rd_chk("unmapped", 12'h040, 32'h0000_0000);
  endtask : s_reset_values
  // Rates far above the 80 to 250 Hz range keep the run short
  task automatic s_program_load;
    apb(1'b1, 12'h010, 32'h0001_0009);
    apb(1'b1, 12'h014, 32'h0000_0004);
    apb(1'b1, 12'h018, 32'h0000_0007);
    apb(1'b1, 12'h00C, 32'h0000_0002);
    apb(1'b1, 12'h100, 32'h0005_0002);
    apb(1'b1, 12'h104, 32'h0009_0000);
    apb(1'b1, 12'h108, 32'h0000_0000);
    apb(1'b1, 12'h10C, 32'h0003_0006);
    apb(1'b1, 12'h180, 32'h0003_0001);
    apb(1'b1, 12'h184, 32'h0006_0002);
    apb(1'b1, 12'h008, 32'h0000_0007);
    apb(1'b1, 12'h000, 32'h0000_0007);
    wait_stat(32'h0000_0007);
    chk("irq on load", 1'b1, irq);
    rd_chk("pending cleared", 12'h000, 32'h0000_0000);
    apb(1'b1, 12'h004, 32'h0000_0007);
    chk("irq cleared", 1'b0, irq);
  endtask : s_program_load
  task automatic s_shapes;
    meas_win(76);
    chk("led0 width", 28, hs[0]);
    chk("led0 periods", 4, rs[0]);
    chk("led1 full on", 76, hs[1]);
    chk("led2 both zero", 12, hs[2]);
    chk("led3 off", 0, hs[3]);
    meas_win(40);
    chk("aux0 on cnt1", 24, hs[24]);
    chk("aux1 on cnt2", 25, hs[25]);
    apb(1'b1, 12'h00C, 32'h0000_0003);
    meas_win(40);
    chk("aux0 on cnt2", 15, hs[24]);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk("count range", 1'b1, q[15:0] <= 16'h0009);
  endtask : s_shapes
  task automatic s_deferred;
    apb(1'b1, 12'h100, 32'h0001_0000);
    meas_win(76);
    chk("led0 kept", 28, hs[0]);
    rd_chk("no load", 12'h004, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0001);
    wait_stat(32'h0000_0001);
    chk("irq led load", 1'b1, irq);
    apb(1'b1, 12'h008, 32'h0000_0000);
    chk("irq masked", 1'b0, irq);
    meas_win(76);
    chk("led0 new", 12, hs[0]);
  endtask : s_deferred
  initial begin
    {pclk, presetn, psel, penable, pwrite, meas} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    bad_count = 0;
    checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_reset_values();
    s_program_load();
    s_shapes();
    s_deferred();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
